/* pkg/sdoic_pkg.sv */
// Purpose: constants and types for the slow-down / origin / index input block
// Assumes: 100 MHz reference clock
// Notes: APB register map lives here
`default_nettype none
package sdoic_pkg;
  // ==========================================================
  // timing
  localparam int CLK_MHZ = 100;
  localparam int SW_FILT_NS = 3000; // switch filter rejects up to this
  localparam int ENC_FILT_NS = 100; // encoder filter rejects up to this
  localparam int SW_FILT_CYC = (SW_FILT_NS * CLK_MHZ) / 1000 + 1;
  localparam int ENC_FILT_CYC = (ENC_FILT_NS * CLK_MHZ) / 1000 + 1;
  localparam int FILT_W = 9;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CMD_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [7:0] ERR_OFS = 8'h0c;
  // control field positions
  localparam int OPSEL_LSB = 0; // 7 bits
  localparam int PINFN_BIT = 8;
  localparam int ACTION_BIT = 9;
  localparam int LATCH_BIT = 10;
  localparam int SDPOL_BIT = 11;
  localparam int ORGPOL_BIT = 12;
  localparam int IDXPOL_BIT = 13;
  localparam int SWFILT_BIT = 14;
  localparam int ENCFILT_BIT = 15;
  localparam int PRESET_LSB = 16; // 4 bits
  localparam int DIR_BIT = 20;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // command codes written to CMD
  localparam logic [7:0] CMD_START_LOW = 8'h50;
  localparam logic [7:0] CMD_START_HIGH = 8'h51;
  localparam logic [7:0] CMD_START_ACC = 8'h52;
  localparam logic [7:0] CMD_START_ACCDEC = 8'h53;
  localparam logic [7:0] CMD_STOP = 8'h49;
  // operation codes using origin and index
  localparam logic [6:0] OP_HOME_P = 7'h10;
  localparam logic [6:0] OP_HOME_M = 7'h18;
  localparam logic [6:0] OP_ESC_P = 7'h12;
  localparam logic [6:0] OP_ESC_M = 7'h1a;
  localparam logic [6:0] OP_SRCH_P = 7'h15;
  localparam logic [6:0] OP_SRCH_M = 7'h1d;
  localparam logic [6:0] OP_IDX_P = 7'h24;
  localparam logic [6:0] OP_IDX_M = 7'h2c;
  // status bit positions
  localparam int ST_RUN = 0;
  localparam int ST_SPEED_LSB = 1; // 2 bits
  localparam int ST_ORIGIN = 14;
  localparam int ST_LATCHED = 15;
  localparam int ST_RAW = 16;
  localparam int ST_INDEX = 17;
  localparam int ST_HOMING = 18;
  localparam int ST_CNT_LSB = 20; // 4 bits
  localparam int ERR_SD_BIT = 10;
  // ==========================================================
  typedef enum logic [1:0] {
    SDOIC_SPD_IDLE = 2'b00,
    SDOIC_SPD_LOW = 2'b01,
    SDOIC_SPD_HIGH = 2'b10,
    SDOIC_SPD_DECEL = 2'b11
  } sdoic_spd_t;
  typedef enum logic [1:0] {
    SDOIC_PAT_LOW = 2'b00,
    SDOIC_PAT_HIGH = 2'b01,
    SDOIC_PAT_ACC = 2'b10
  } sdoic_pat_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } sdoic_apb_req_t;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } sdoic_apb_rsp_t;
  typedef struct packed {
    logic sd_p;
    logic sd_m;
    logic origin;
    logic index;
  } sdoic_pins_t;
  typedef struct packed {
    logic pulse_en;
    logic target_high;
    logic halt;
    logic gpio_sd;
  } sdoic_motion_t;
endpackage
`default_nettype wire

/* logic/sdoic_top.sv */
// Purpose: slow-down, origin and index input control for one axis
// Assumes: inputs synchronous-ish, resynchronised here; 100 MHz clock
// Notes: speed ramping is outside; this block steers it via target_high
// Function
// - pin-function bit 0 makes slow-down a plain input; 1 enables decel/stop.
// - action and latch bits choose among four slow-down behaviours.
// - decelerate-only behaviours ignore slow-down on constant-speed patterns.
// - unlatched decel drops to low speed, re-accelerates when input releases.
// - input active at accelerating start runs low; latch keeps it low.
// - latched decel never re-accelerates after slow-down seen.
// - stop behaviours halt pulses at once on constant-speed patterns.
// - stop behaviours on accel pattern decelerate then stop; unlatched may recover.
// - stop behaviours with input active at start finish without pulses.
// - slow-down stop sets the slow-down error cause bit when stopping.
// - slow-down polarity bit 0 active-low, 1 active-high.
// - latch enabled sets and holds latched-status when input activates.
// - latched-status clears at start if input inactive.
// - latch disabled makes latched-status equal raw status.
// - shared switch filter: off passes short pulses, on rejects up to 3 us.
// - origin polarity bit 0 active-low, 1 active-high.
// - origin status reflects filtered origin input.
// - index polarity selectable; counted on inactive-to-active edge.
// - encoder filter: on rejects up to 0.10 us, accepts from 0.15 us.
// - 4-bit index down-counter preloads from preset; code 0 loads zero, so no edge is counted.
// - index edge two clocks after origin activation is counted.
// - operation-select codes for homing, escape, search and index-move all set the one homing flag.
`timescale 1ns/1ps
`default_nettype none
module sdoic_top #(
  parameter int SW_CYC = sdoic_pkg::SW_FILT_CYC,
  parameter int ENC_CYC = sdoic_pkg::ENC_FILT_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // apb slave
  input wire sdoic_pkg::sdoic_apb_req_t apb_req,
  output var sdoic_pkg::sdoic_apb_rsp_t apb_rsp,
  // switch and encoder pins
  input wire sdoic_pkg::sdoic_pins_t pins,
  // ramp handshake input and motion control outputs
  input wire logic decel_done,
  output var sdoic_pkg::sdoic_motion_t motion,
  output var sdoic_pkg::sdoic_spd_t speed_state
);
  import sdoic_pkg::*;

  // refuse filter counts that the persistence counters cannot hold
  if (SW_CYC < 2 || SW_CYC >= (1 << FILT_W) || ENC_CYC < 2 || ENC_CYC >= (1 << FILT_W))
  begin : g_bad_filt
    $error("filter count out of range");
  end

  typedef struct packed {
    logic [31:0] ctrl;
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] filt;
    logic [3:0][FILT_W-1:0] fcnt;
    logic idx_prev;
    logic latched;
    logic err_sd;
    logic running;
    logic homing;
    sdoic_pat_t pat;
    sdoic_spd_t spd;
    logic stop_pend;
    logic [3:0] idx_cnt;
    logic [1:0] org_age;
    sdoic_apb_rsp_t rsp;
    sdoic_motion_t mo;
  } sdoic_state_t;

  sdoic_state_t st_q;
  sdoic_state_t st_d;

  // ==========================================================
  // derived levels
  logic sd_dir_raw;
  logic sd_act;
  logic org_act;
  logic idx_act;
  logic pinfn;
  logic action;
  logic latch_en;
  logic wr;
  logic rd;
  logic start_cmd;
  logic [7:0] cmd;
  logic idx_edge;
  logic sd_eff;

  // pick filtered inputs and apply polarity
  always_comb
  begin
    pinfn = st_q.ctrl[PINFN_BIT];
    action = st_q.ctrl[ACTION_BIT];
    latch_en = st_q.ctrl[LATCH_BIT];
    sd_dir_raw = st_q.ctrl[DIR_BIT] ? st_q.filt[2] : st_q.filt[3]; // travel direction switch
    sd_act = sd_dir_raw ~^ st_q.ctrl[SDPOL_BIT];
    org_act = st_q.filt[1] ~^ st_q.ctrl[ORGPOL_BIT];
    idx_act = st_q.filt[0] ~^ st_q.ctrl[IDXPOL_BIT];
    idx_edge = idx_act && !st_q.idx_prev;
    wr = apb_req.psel && apb_req.penable && apb_req.pwrite && st_q.rsp.pready; // lands at the ready edge
    rd = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
    cmd = apb_req.pwdata[7:0];
    start_cmd = wr && apb_req.paddr == CMD_OFS && !st_q.running &&
      (cmd == CMD_START_LOW || cmd == CMD_START_HIGH || cmd == CMD_START_ACC || cmd == CMD_START_ACCDEC);
    sd_eff = pinfn && sd_act;
  end

  // ==========================================================
  // next state
  always_comb
  begin
    logic [6:0] op;
    logic [3:0] raw;
    logic [FILT_W-1:0] lim;
    lim = '0;
    st_d = st_q;
    op = st_q.ctrl[OPSEL_LSB +: 7];
    raw = {pins.sd_p, pins.sd_m, pins.origin, pins.index};
    // two-stage synchroniser on every pin
    st_d.s1 = raw;
    st_d.s2 = st_q.s1;
    // persistence filters: output follows only after a stable run
    for (int i = 0; i < 4; i++)
    begin
      if (i == 0)
        lim = st_q.ctrl[ENCFILT_BIT] ? FILT_W'(ENC_CYC) : FILT_W'(1);
      else
        lim = st_q.ctrl[SWFILT_BIT] ? FILT_W'(SW_CYC) : FILT_W'(1);
      if (st_q.s2[i] == st_q.filt[i])
        st_d.fcnt[i] = '0;
      else if (st_q.fcnt[i] + FILT_W'(1) >= lim)
      begin
        st_d.filt[i] = st_q.s2[i];
        st_d.fcnt[i] = '0;
      end
      else
        st_d.fcnt[i] = st_q.fcnt[i] + FILT_W'(1);
    end
    st_d.idx_prev = idx_act;
    // origin age: counts clocks since origin went active, saturates at 2
    if (!org_act)
      st_d.org_age = 2'd0;
    else if (st_q.org_age != 2'd2)
      st_d.org_age = st_q.org_age + 2'd1;
    // index down-counter: preload, then decrement on counted edges
    if (start_cmd)
      st_d.idx_cnt = st_q.ctrl[PRESET_LSB +: 4];
    else if (idx_edge && (!st_q.homing || st_q.org_age == 2'd2) && st_q.idx_cnt != 4'h0)
      st_d.idx_cnt = st_q.idx_cnt - 4'h1;
    // latched state
    if (!latch_en)
      st_d.latched = sd_act;
    else if (sd_act)
      st_d.latched = 1'b1;
    if (start_cmd && !sd_act)
      st_d.latched = 1'b0;
    st_d.mo.gpio_sd = sd_act && !pinfn;
    st_d.mo.halt = 1'b0;
    // apb answer: one wait state, ready in access phase
    st_d.rsp.pready = apb_req.psel && apb_req.penable && !st_q.rsp.pready;
    if (rd)
    begin
      st_d.rsp.pslverr = 1'b0; // error flag stands until the next setup
      case (apb_req.paddr)
        CTRL_OFS: st_d.rsp.prdata = st_q.ctrl;
        STAT_OFS:
        begin
          st_d.rsp.prdata = '0;
          st_d.rsp.prdata[ST_RUN] = st_q.running;
          st_d.rsp.prdata[ST_SPEED_LSB +: 2] = st_q.spd;
          st_d.rsp.prdata[ST_ORIGIN] = org_act;
          st_d.rsp.prdata[ST_LATCHED] = st_q.latched;
          st_d.rsp.prdata[ST_RAW] = sd_act;
          st_d.rsp.prdata[ST_INDEX] = idx_act;
          st_d.rsp.prdata[ST_HOMING] = st_q.homing;
          st_d.rsp.prdata[ST_CNT_LSB +: 4] = st_q.idx_cnt;
        end
        ERR_OFS:
        begin
          st_d.rsp.prdata = '0;
          st_d.rsp.prdata[ERR_SD_BIT] = st_q.err_sd;
        end
        CMD_OFS: st_d.rsp.prdata = '0;
        default:
        begin
          st_d.rsp.prdata = '0;
          st_d.rsp.pslverr = 1'b1;
        end
      endcase
    end
    else if (apb_req.psel && !apb_req.penable)
    begin
      st_d.rsp.prdata = '0;
      st_d.rsp.pslverr = !(apb_req.paddr == CTRL_OFS || apb_req.paddr == CMD_OFS ||
        apb_req.paddr == ERR_OFS);
    end
    if (wr && apb_req.paddr == CTRL_OFS)
      st_d.ctrl = apb_req.pwdata;
    // error flag: write one to clear, a new stop wins
    if (wr && apb_req.paddr == ERR_OFS && apb_req.pwdata[ERR_SD_BIT])
      st_d.err_sd = 1'b0;
    // start handling
    if (start_cmd)
    begin
      st_d.homing = op == OP_HOME_P || op == OP_HOME_M || op == OP_ESC_P || op == OP_ESC_M ||
        op == OP_SRCH_P || op == OP_SRCH_M || op == OP_IDX_P || op == OP_IDX_M;
      st_d.pat = cmd == CMD_START_LOW ? SDOIC_PAT_LOW :
        cmd == CMD_START_HIGH ? SDOIC_PAT_HIGH : SDOIC_PAT_ACC;
      if (sd_eff && action)
      begin
        // completes without pulses
        st_d.running = 1'b0;
        st_d.spd = SDOIC_SPD_IDLE;
        st_d.err_sd = 1'b1;
      end
      else
      begin
        st_d.running = 1'b1;
        if (cmd == CMD_START_LOW)
          st_d.spd = SDOIC_SPD_LOW;
        else if (cmd == CMD_START_HIGH)
          st_d.spd = SDOIC_SPD_HIGH;
        else
          st_d.spd = sd_eff ? SDOIC_SPD_LOW : SDOIC_SPD_HIGH;
      end
    end
    else if (wr && apb_req.paddr == CMD_OFS && cmd == CMD_STOP)
    begin
      st_d.running = 1'b0;
      st_d.spd = SDOIC_SPD_IDLE;
    end
    else if (st_q.running)
    begin
      if (st_q.pat != SDOIC_PAT_ACC)
      begin
        // constant patterns: ignore or halt at once
        if (sd_eff && action)
        begin
          st_d.running = 1'b0;
          st_d.spd = SDOIC_SPD_IDLE;
          st_d.err_sd = 1'b1;
          st_d.mo.halt = 1'b1;
        end
      end
      else
      begin
        case (st_q.spd)
          SDOIC_SPD_HIGH:
            if (sd_eff)
              st_d.spd = SDOIC_SPD_DECEL;
          SDOIC_SPD_DECEL:
            if (!sd_eff && !latch_en)
              st_d.spd = SDOIC_SPD_HIGH;
            else if (decel_done)
            begin
              if (action)
              begin
                st_d.running = 1'b0;
                st_d.spd = SDOIC_SPD_IDLE;
                st_d.err_sd = 1'b1;
              end
              else
                st_d.spd = SDOIC_SPD_LOW;
            end
          SDOIC_SPD_LOW:
            if (!sd_eff && !latch_en)
              st_d.spd = SDOIC_SPD_HIGH;
            else if (sd_eff && action)
            begin
              st_d.running = 1'b0;
              st_d.spd = SDOIC_SPD_IDLE;
              st_d.err_sd = 1'b1;
            end
          // latched low speed stays put
          default: st_d.spd = SDOIC_SPD_IDLE;
        endcase
      end
    end
    st_d.mo.pulse_en = st_d.running;
    st_d.mo.target_high = st_d.spd == SDOIC_SPD_HIGH;
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_q <= '0;
      st_q.ctrl <= CTRL_RST;
      // pins idle high under the reset polarity, so no false edge after reset
      st_q.s1 <= '1;
      st_q.s2 <= '1;
      st_q.filt <= '1;
    end
    else
      st_q <= st_d;
  end

  assign apb_rsp = st_q.rsp;
  assign motion = st_q.mo;
  assign speed_state = st_q.spd;

  // ==========================================================
  // checks
  latch_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    st_q.ctrl[LATCH_BIT] && st_q.latched && !start_cmd |=> st_q.latched)
    else $error("latched state dropped");
  latch_follow_a: assert property (@(posedge clk) disable iff (sys_rst)
    !st_q.ctrl[LATCH_BIT] && !start_cmd && $stable(st_q.ctrl) |=> st_q.latched == $past(sd_act))
    else $error("latched state not following raw");
  start_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    start_cmd && !sd_act |=> !st_q.latched)
    else $error("latched state not cleared at start");
  nopulse_start_a: assert property (@(posedge clk) disable iff (sys_rst)
    start_cmd && sd_eff && action |=> !st_q.running && st_q.err_sd)
    else $error("start with active stop input ran");
  const_halt_a: assert property (@(posedge clk) disable iff (sys_rst)
    st_q.running && st_q.pat != SDOIC_PAT_ACC && sd_eff && action && !start_cmd && !wr |=> !st_q.running)
    else $error("constant pattern not halted");
  const_ignore_a: assert property (@(posedge clk) disable iff (sys_rst)
    st_q.running && st_q.pat != SDOIC_PAT_ACC && !action && !wr |=> st_q.running && $stable(st_q.spd))
    else $error("constant pattern reacted to slow-down");
  latch_nore_a: assert property (@(posedge clk) disable iff (sys_rst)
    st_q.running && st_q.spd == SDOIC_SPD_LOW && st_q.ctrl[LATCH_BIT] && !wr |=> st_q.spd != SDOIC_SPD_HIGH)
    else $error("latched decel re-accelerated");
  idx_load_a: assert property (@(posedge clk) disable iff (sys_rst)
    start_cmd |=> st_q.idx_cnt == $past(st_q.ctrl[PRESET_LSB +: 4]))
    else $error("index counter not preloaded");
  org_window_a: assert property (@(posedge clk) disable iff (sys_rst)
    !start_cmd && st_q.homing && idx_edge && st_q.org_age == 2'd0 |=> $stable(st_q.idx_cnt))
    else $error("index counted too soon after origin");
  // slow-down steering and error flag
  gpio_ignore_a: assert property (@(posedge clk) disable iff (sys_rst)
    !pinfn && st_q.running && st_q.spd == SDOIC_SPD_HIGH && !wr |=> st_q.spd == SDOIC_SPD_HIGH)
    else $error("general-purpose slow-down pin changed speed");
  gpio_quiet_a: assert property (@(posedge clk) disable iff (sys_rst)
    pinfn |=> !st_q.mo.gpio_sd)
    else $error("gpio mirror high while pin steers motion");
  acc_slow_a: assert property (@(posedge clk) disable iff (sys_rst)
    st_q.running && st_q.pat == SDOIC_PAT_ACC && st_q.spd == SDOIC_SPD_HIGH && sd_eff && !wr
    |=> st_q.spd == SDOIC_SPD_DECEL)
    else $error("accelerating pattern did not slow down");
  acc_start_a: assert property (@(posedge clk) disable iff (sys_rst)
    start_cmd && sd_eff && !action && (cmd == CMD_START_ACC || cmd == CMD_START_ACCDEC)
    |=> st_q.spd == SDOIC_SPD_LOW)
    else $error("start with slow-down active not at low speed");
  halt_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
    st_q.mo.halt |=> !st_q.mo.halt)
    else $error("halt longer than one cycle");
  stop_err_a: assert property (@(posedge clk) disable iff (sys_rst)
    st_q.running && !wr |=> st_q.running || st_q.err_sd)
    else $error("slow-down stop without error flag");
  err_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
    st_q.err_sd && !(wr && apb_req.paddr == ERR_OFS && apb_req.pwdata[ERR_SD_BIT]) |=> st_q.err_sd)
    else $error("error flag dropped without clear");
  // input path and index counter
  filt_sync_a: assert property (@(posedge clk) disable iff (sys_rst)
    $changed(st_q.filt[3]) |-> st_q.filt[3] == $past(st_q.s2[3]))
    else $error("filter took an unsynchronised level");
  idx_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !start_cmd && !idx_edge |=> $stable(st_q.idx_cnt))
    else $error("index counter moved without an edge");
  idx_step_a: assert property (@(posedge clk) disable iff (sys_rst)
    !start_cmd && st_q.homing && idx_edge && st_q.org_age == 2'd2 && st_q.idx_cnt != 4'h0
    |=> st_q.idx_cnt == $past(st_q.idx_cnt) - 4'h1)
    else $error("late index edge not counted");
  idx_floor_a: assert property (@(posedge clk) disable iff (sys_rst)
    st_q.idx_cnt == 4'h0 && !start_cmd |=> st_q.idx_cnt == 4'h0)
    else $error("index counter wrapped below zero");
endmodule
`default_nettype wire

/* bench/sdoic_switch_model.sv */
// Purpose: switch, index and speed ramp stand-in for one axis
// Assumes: bench gives logical on/off states and the polarity in use
// Notes: decel_done comes RAMP cycles after the target drops to low
`timescale 1ns/1ps
`default_nettype none
module sdoic_switch_model
  import sdoic_pkg::*;
#(
  parameter int RAMP = 40
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // logical states, polarity {index, origin, slow-down}
  input wire logic sd_on,
  input wire logic org_on,
  input wire logic idx_on,
  input wire logic [2:0] pol,
  // ramp handshake and pins
  input wire sdoic_pkg::sdoic_motion_t motion,
  output logic decel_done,
  output wire sdoic_pkg::sdoic_pins_t pins
);
  int n;
  // pin levels; minus-side switch held inactive
  assign pins = {sd_on ~^ pol[0], ~pol[0], org_on ~^ pol[1], idx_on ~^ pol[2]}; // level
  // ramp counts while running below target high
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
      n <= 0;
    else if (!motion.pulse_en || motion.target_high)
      n <= 0;
    else if (n < RAMP)
      n <= n + 1;
  assign decel_done = (n == RAMP);
endmodule
`default_nettype wire

/* bench/sdoic_top_tb_top.sv */
// Purpose: self-checking bench for slow-down, origin and index inputs
// Assumes: filter counts shortened to 4 cycles
// Notes: registers over APB, one wait state
`timescale 1ns/1ps
`default_nettype none
module sdoic_top_tb_top;
  import sdoic_pkg::*;
  localparam logic [31:0] PF = 32'h1 << PINFN_BIT;
  localparam logic [31:0] AC = 32'h1 << ACTION_BIT;
  localparam logic [31:0] LT = 32'h1 << LATCH_BIT;
  localparam logic [31:0] FS = 32'h1 << SWFILT_BIT;
  localparam logic [31:0] PR = 32'h2 << PRESET_LSB;
  localparam logic [31:0] ES = 32'h1 << ERR_SD_BIT;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic decel_done;
  logic sd_on = 1'b0;
  logic org_on = 1'b0;
  logic idx_on = 1'b0;
  logic [2:0] pol = 3'h0;
  logic [31:0] rd;
  logic er;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  int halts = 0;
  int gp = 0;
  int pe = 0;
  sdoic_apb_req_t req = '0;
  sdoic_apb_rsp_t rsp;
  sdoic_pins_t pins;
  sdoic_motion_t motion;
  sdoic_spd_t speed_state;
  // ==========================================================
  // design and far side
  sdoic_top #(.SW_CYC(4), .ENC_CYC(4)) DUT (.clk(clk), .sys_rst(sys_rst), .apb_req(req), .apb_rsp(rsp),
    .pins(pins), .decel_done(decel_done), .motion(motion), .speed_state(speed_state));
  sdoic_switch_model SW (.clk(clk), .sys_rst(sys_rst), .sd_on(sd_on), .org_on(org_on), .idx_on(idx_on),
    .pol(pol), .motion(motion), .decel_done(decel_done), .pins(pins));
  // clock
  initial
    forever #5 clk = ~clk;
  // output watch and hang limit
  always @(posedge clk)
  begin
    cyc++;
    halts += int'(motion.halt === 1'b1);
    gp += int'(motion.gpio_sd === 1'b1);
    pe += int'(motion.pulse_en === 1'b1);
    if (cyc == 30000)
    begin
      fails++;
      conclude();
    end
  end
  // ==========================================================
  // shared tasks
  task automatic conclude();
    if (fails == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      fails++;
      $display("unexpected %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic sb(input string nm, input int b, input logic v);
    apb(1'b0, STAT_OFS, 32'h0);
    chk(nm, 32'(rd[b]), 32'(v));
  endtask
  task automatic wpe(input logic v);
    int n;
    n = 0;
    while (motion.pulse_en !== v && n < 80)
    begin
      @(posedge clk);
      n++;
    end
    chk("pulse_en", 32'(motion.pulse_en), 32'(v));
  endtask
  task automatic wsp(input sdoic_spd_t v);
    int n;
    n = 0;
    while (speed_state !== v && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    chk("speed", 32'(speed_state), 32'(v));
  endtask
  task automatic stop();
    wr(CMD_OFS, 32'(CMD_STOP));
    sd_on <= 1'b0;
    wpe(1'b0);
    wr(ERR_OFS, ES);
    cy(20);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    apb(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl", rd, CTRL_RST);
    apb(1'b0, STAT_OFS, 32'h0);
    chk("stat", rd & 32'h7ffff, 32'h0); // idle inputs
    apb(1'b0, 8'h10, 32'h0);
    chk("slverr", 32'(er), 32'h1);
  endtask
  task automatic t_pol();
    sd_on <= 1'b1;
    org_on <= 1'b1;
    cy(20);
    sb("raw", ST_RAW, 1'b1); // low active
    sb("latched", ST_LATCHED, 1'b1); // follows raw
    sb("origin", ST_ORIGIN, 1'b1); // low active
    wr(CTRL_OFS, 32'h1 << DIR_BIT);
    cy(20);
    sb("raw", ST_RAW, 1'b0); // minus side idle
    pol <= 3'h7;
    wr(CTRL_OFS, 32'h7 << SDPOL_BIT);
    cy(20);
    sb("raw", ST_RAW, 1'b1); // high active
    sb("origin", ST_ORIGIN, 1'b1); // high active
    sd_on <= 1'b0;
    org_on <= 1'b0;
    cy(20);
    sb("latched", ST_LATCHED, 1'b0); // clears
    sb("origin", ST_ORIGIN, 1'b0); // released
    pol <= 3'h0;
    wr(CTRL_OFS, 32'h0);
    cy(20);
  endtask
  task automatic t_filt(input logic [31:0] c, input logic pass);
    int g;
    wr(CTRL_OFS, c);
    cy(20);
    g = gp;
    sd_on <= 1'b1;
    cy(2);
    sd_on <= 1'b0;
    cy(20);
    chk("gpio_sd", 32'(gp != g), 32'(pass)); // short pulse
  endtask
  task automatic t_stopc();
    int h;
    wr(CTRL_OFS, PF | AC);
    wr(CMD_OFS, 32'(CMD_START_HIGH));
    wpe(1'b1);
    h = halts;
    sd_on <= 1'b1;
    wpe(1'b0); // stops
    cy(1);
    chk("halt", 32'(halts - h), 32'h1); // one pulse
    apb(1'b0, ERR_OFS, 32'h0);
    chk("err", rd & ES, ES); // set on stop
    wr(ERR_OFS, ES);
    apb(1'b0, ERR_OFS, 32'h0);
    chk("err clr", rd & ES, 32'h0); // write one clears
    stop();
  endtask
  task automatic t_nostart();
    int p;
    wr(CTRL_OFS, PF | AC | LT);
    sd_on <= 1'b1;
    cy(20);
    p = pe;
    wr(CMD_OFS, 32'(CMD_START_LOW));
    cy(30);
    chk("no pulse", 32'(pe - p), 32'h0); // never runs
    sd_on <= 1'b0;
    cy(20);
    sb("latched", ST_LATCHED, 1'b1); // held
    wr(CMD_OFS, 32'(CMD_START_LOW));
    sb("latched", ST_LATCHED, 1'b0); // cleared at start
    stop();
  endtask
  task automatic t_ign();
    wr(CTRL_OFS, PF);
    wr(CMD_OFS, 32'(CMD_START_LOW));
    wpe(1'b1);
    sd_on <= 1'b1;
    cy(30);
    chk("run", 32'(motion.pulse_en), 32'h1); // ignored
    chk("speed", 32'(speed_state), 32'(SDOIC_SPD_LOW)); // ignored
    stop();
  endtask
  task automatic t_acc(input logic [31:0] c, input int k);
    wr(CTRL_OFS, c);
    wr(CMD_OFS, 32'(CMD_START_ACC));
    wsp(SDOIC_SPD_HIGH);
    chk("target_high", 32'(motion.target_high), 32'h1);
    sd_on <= 1'b1;
    wsp(SDOIC_SPD_DECEL); // slows
    sd_on <= 1'b0;
    if (k == 0)
      wsp(SDOIC_SPD_HIGH); // recovers
    else if (k == 1)
      wsp(SDOIC_SPD_LOW); // no recovery
    else
      wpe(1'b0); // stops
    cy(60);
    if (k == 1)
    begin
      chk("speed", 32'(speed_state), 32'(SDOIC_SPD_LOW)); // stays low
      chk("target_high", 32'(motion.target_high), 32'h0);
    end
    stop();
  endtask
  task automatic t_astart(input logic [31:0] c, input logic lat);
    wr(CTRL_OFS, c);
    sd_on <= 1'b1;
    cy(20);
    wr(CMD_OFS, 32'(CMD_START_ACCDEC));
    wsp(SDOIC_SPD_LOW); // low start
    sd_on <= 1'b0;
    cy(60);
    chk("speed", 32'(speed_state), 32'(lat ? SDOIC_SPD_LOW : SDOIC_SPD_HIGH)); // after release
    stop();
  endtask
  task automatic ip(input int n);
    repeat (n)
    begin
      idx_on <= 1'b1;
      cy(10);
      idx_on <= 1'b0;
      cy(10);
    end
  endtask
  task automatic t_home();
    logic [6:0] ops [8] = '{OP_HOME_P, OP_HOME_M, OP_ESC_P, OP_ESC_M, OP_SRCH_P, OP_SRCH_M, OP_IDX_P, OP_IDX_M};
    foreach (ops[i])
    begin
      wr(CTRL_OFS, PR | 32'(ops[i]));
      wr(CMD_OFS, 32'(CMD_START_LOW));
      apb(1'b0, STAT_OFS, 32'h0);
      chk("homing", 32'(rd[ST_HOMING]), 32'h1); // mode
      chk("count", 32'(rd[ST_CNT_LSB +: 4]), 32'h2); // preload
      stop();
    end
    wr(CTRL_OFS, PR | 32'(OP_HOME_P));
    wr(CMD_OFS, 32'(CMD_START_LOW));
    org_on <= 1'b1;
    ip(1);
    apb(1'b0, STAT_OFS, 32'h0);
    chk("count", 32'(rd[ST_CNT_LSB +: 4]), 32'h2); // same edge
    ip(1);
    apb(1'b0, STAT_OFS, 32'h0);
    chk("count", 32'(rd[ST_CNT_LSB +: 4]), 32'h1); // late edge
    ip(3);
    apb(1'b0, STAT_OFS, 32'h0);
    chk("count", 32'(rd[ST_CNT_LSB +: 4]), 32'h0); // holds at zero
    org_on <= 1'b0;
    stop();
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_pol();
    t_filt(FS, 1'b0);
    t_filt(32'h0, 1'b1);
    t_stopc();
    t_nostart();
    t_ign();
    t_acc(PF, 0);
    t_acc(PF | LT, 1);
    t_acc(PF | AC, 0);
    t_acc(PF | AC | LT, 2);
    t_astart(PF, 1'b0);
    t_astart(PF | LT, 1'b1);
    t_home();
    conclude();
  end
endmodule
`default_nettype wire
